// ===== design/chgsp_regs.svh
// Register offsets, field positions, reset values and timing figures of the setpoint bank.
// Assumes an I2C slave front end that presents single-byte register accesses.
`ifndef CHGSP_REGS_SVH
`define CHGSP_REGS_SVH

`define CHGSP_ADDR_CUR_LO   8'h02
`define CHGSP_ADDR_CUR_HI   8'h03
`define CHGSP_ADDR_VOLT_LO  8'h04
`define CHGSP_ADDR_VOLT_HI  8'h05

`define CHGSP_CUR_MSB       13
`define CHGSP_CUR_LSB       3
`define CHGSP_VOLT_MSB      14
`define CHGSP_VOLT_LSB      2

`define CHGSP_CUR_RESET     16'h0000
`define CHGSP_VOLT_RESET    16'h0000

`define CHGSP_CUR_MAX_5M    11'h7F8
`define CHGSP_CUR_MAX_2M    11'h5DC
`define CHGSP_CUR_FLOOR_MA  128
`define CHGSP_CUR_STEP_5M   8
`define CHGSP_CUR_STEP_2M   20

`define CHGSP_VOLT_MIN      13'h04E2
`define CHGSP_VOLT_MAX      13'h1676
`define CHGSP_VOLT_DEF_2S   13'h0834
`define CHGSP_VOLT_DEF_3S   13'h0C4E
`define CHGSP_VOLT_DEF_4S   13'h1068
`define CHGSP_VOLT_DEF_5S   13'h1482

`define CHGSP_STATE_DONE    3'h7

`define CHGSP_CLK_MHZ       250
`define CHGSP_WD_P1_SEC     5
`define CHGSP_WD_P2_SEC     88
`define CHGSP_WD_P3_SEC     175

`endif

// ===== design/chgsp_pkg.sv
// Types shared by the setpoint bank and its watchdog.
// Assumes the constants of chgsp_regs.svh.
package chgsp_pkg;

	typedef enum logic [1:0] {
		CHGSP_CELLS_2 = 2'b00,
		CHGSP_CELLS_3 = 2'b01,
		CHGSP_CELLS_4 = 2'b10,
		CHGSP_CELLS_5 = 2'b11
	} chgsp_cells_t;

	typedef enum logic [1:0] {
		CHGSP_WD_OFF = 2'b00,
		CHGSP_WD_P1  = 2'b01,
		CHGSP_WD_P2  = 2'b10,
		CHGSP_WD_P3  = 2'b11
	} chgsp_wd_sel_t;

	typedef struct packed {
		logic [31:0]   tick;
		logic [7:0]    secs;
		logic          running;
		chgsp_wd_sel_t prev_sel;
		logic          expire;
	} chgsp_wd_state_t;

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] volt;
		logic [15:0] cur_buf;
		logic [1:0]  cur_seen;
		logic [15:0] volt_buf;
		logic [1:0]  volt_seen;
		logic        init_done;
		logic        chg_en;
		logic [7:0]  rdata;
	} chgsp_state_t;

endpackage : chgsp_pkg

// ===== design/chgsp_wd_if.sv
// Link between the setpoint bank and its watchdog timer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface chgsp_wd_if;
	logic                    kick;
	chgsp_pkg::chgsp_wd_sel_t period_sel;
	logic                    expire;

	modport timer (input kick, input period_sel, output expire);
	modport bank  (output kick, output period_sel, input expire);
endinterface : chgsp_wd_if

// ===== design/chgsp_watchdog.sv
// Watchdog on host setpoint writes; pulses expire when the period lapses.
// Assumes kick pulses on every setpoint byte write.
`timescale 1ns/100ps
`include "chgsp_regs.svh"
module chgsp_watchdog #(
	parameter int unsigned TICKS_PER_SEC = `CHGSP_CLK_MHZ * 1000000
) (
	clk,
	rst,
	wd
);
	input wire logic  clk;
	input wire logic  rst;
	chgsp_wd_if.timer wd;

	chgsp_pkg::chgsp_wd_state_t st;
	chgsp_pkg::chgsp_wd_state_t next_st;
	logic [7:0]                 limit;

	always_comb begin
		unique case (wd.period_sel)
			chgsp_pkg::CHGSP_WD_OFF: limit = 8'h00;
			chgsp_pkg::CHGSP_WD_P1:  limit = 8'(`CHGSP_WD_P1_SEC);
			chgsp_pkg::CHGSP_WD_P2:  limit = 8'(`CHGSP_WD_P2_SEC);
			chgsp_pkg::CHGSP_WD_P3:  limit = 8'(`CHGSP_WD_P3_SEC);
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.expire = 1'b0;
		next_st.prev_sel = wd.period_sel;
		if (wd.kick || (wd.period_sel != st.prev_sel)) begin
			next_st.tick = 32'h0;
			next_st.secs = 8'h00;
			next_st.running = 1'b1;
		end else if (st.running && (limit != 8'h00)) begin
			if (st.tick == 32'(TICKS_PER_SEC - 1)) begin
				next_st.tick = 32'h0;
				next_st.secs = st.secs + 8'h01;
				if ((st.secs + 8'h01) >= limit) begin
					next_st.expire = 1'b1;
					next_st.running = 1'b0;
				end
			end else begin
				next_st.tick = st.tick + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{tick: 32'h0, secs: 8'h00, running: 1'b1,
				prev_sel: chgsp_pkg::CHGSP_WD_OFF, expire: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign wd.expire = st.expire;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wd_kick_quiet_a: assert property (wd.kick |=> ##1 !wd.expire)
		else $error("watchdog expired right after a setpoint write");
	wd_off_quiet_a: assert property ((wd.period_sel == chgsp_pkg::CHGSP_WD_OFF)
		&& $stable(wd.period_sel) |=> !wd.expire)
		else $error("watchdog expired while disabled");

endmodule : chgsp_watchdog

// ===== design/chgsp_top.sv
// Charge current and charge voltage setpoint registers of the charge controller.
// Assumes a byte-wide register port behind the I2C slave, one access per cycle.
`timescale 1ns/100ps
`include "chgsp_regs.svh"
module chgsp_top #(
	parameter int unsigned WD_TICKS_PER_SEC = `CHGSP_CLK_MHZ * 1000000
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     reg_wr_en,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic [7:0]               reg_rd_addr,
	output logic      [7:0]               reg_rdata,
	input  wire logic                     reg_reset_cmd,
	input  wire chgsp_pkg::chgsp_cells_t  cell_count,
	input  wire logic                     sense_resistor_select,
	input  wire chgsp_pkg::chgsp_wd_sel_t watchdog_period_select,
	input  wire logic                     charge_block_bit,
	input  wire logic                     battery_overcurrent_fault,
	input  wire logic                     battery_present_input,
	input  wire logic                     adapter_valid_flag,
	input  wire logic [2:0]               charge_state_field,
	input  wire logic                     safety_timer_event,
	output logic      [15:0]              charge_current_limit,
	output logic      [15:0]              charge_voltage_target,
	output logic                          charge_enable
);
	localparam logic [10:0] CUR_FLOOR_5M = 11'((`CHGSP_CUR_FLOOR_MA + `CHGSP_CUR_STEP_5M - 1)
		/ `CHGSP_CUR_STEP_5M);
	localparam logic [10:0] CUR_FLOOR_2M = 11'((`CHGSP_CUR_FLOOR_MA + `CHGSP_CUR_STEP_2M - 1)
		/ `CHGSP_CUR_STEP_2M);

	chgsp_pkg::chgsp_state_t st;
	chgsp_pkg::chgsp_state_t next_st;
	chgsp_wd_if              wd_link ();
	logic [12:0]             volt_default;
	logic [10:0]             cur_max;
	logic [10:0]             cur_floor;
	logic [15:0]             cur_asm;
	logic [15:0]             volt_asm;
	logic [10:0]             cur_raw;
	logic [12:0]             volt_raw;
	logic [10:0]             cur_fix;
	logic [12:0]             volt_fix;
	logic                    cur_commit;
	logic                    volt_commit;
	logic                    clear_evt;
	logic                    volt_ok;

	chgsp_watchdog #(
		.TICKS_PER_SEC (WD_TICKS_PER_SEC)
	) u_watchdog (
		.clk (clk),
		.rst (rst),
		.wd  (wd_link.timer)
	);

	assign wd_link.kick = reg_wr_en && (reg_addr >= `CHGSP_ADDR_CUR_LO)
		&& (reg_addr <= `CHGSP_ADDR_VOLT_HI);
	assign wd_link.period_sel = watchdog_period_select;

	always_comb begin
		unique case (cell_count)
			chgsp_pkg::CHGSP_CELLS_2: volt_default = `CHGSP_VOLT_DEF_2S;
			chgsp_pkg::CHGSP_CELLS_3: volt_default = `CHGSP_VOLT_DEF_3S;
			chgsp_pkg::CHGSP_CELLS_4: volt_default = `CHGSP_VOLT_DEF_4S;
			chgsp_pkg::CHGSP_CELLS_5: volt_default = `CHGSP_VOLT_DEF_5S;
		endcase
	end

	assign cur_max = sense_resistor_select ? `CHGSP_CUR_MAX_2M : `CHGSP_CUR_MAX_5M;
	assign cur_floor = sense_resistor_select ? CUR_FLOOR_2M : CUR_FLOOR_5M;

	always_comb begin
		cur_asm = st.cur_buf;
		volt_asm = st.volt_buf;
		cur_commit = 1'b0;
		volt_commit = 1'b0;
		if (reg_wr_en) begin
			unique case (reg_addr)
				`CHGSP_ADDR_CUR_LO: cur_asm[7:0] = reg_wdata;
				`CHGSP_ADDR_CUR_HI: cur_asm[15:8] = reg_wdata;
				`CHGSP_ADDR_VOLT_LO: volt_asm[7:0] = reg_wdata;
				`CHGSP_ADDR_VOLT_HI: volt_asm[15:8] = reg_wdata;
				default: ;
			endcase
			cur_commit = ((reg_addr == `CHGSP_ADDR_CUR_LO) && st.cur_seen[1])
				|| ((reg_addr == `CHGSP_ADDR_CUR_HI) && st.cur_seen[0]);
			volt_commit = ((reg_addr == `CHGSP_ADDR_VOLT_LO) && st.volt_seen[1])
				|| ((reg_addr == `CHGSP_ADDR_VOLT_HI) && st.volt_seen[0]);
		end
		cur_raw = cur_asm[`CHGSP_CUR_MSB:`CHGSP_CUR_LSB];
		volt_raw = volt_asm[`CHGSP_VOLT_MSB:`CHGSP_VOLT_LSB];
	end

	always_comb begin
		if (cur_raw > cur_max) begin
			cur_fix = cur_max;
		end else if ((cur_raw != 11'h000) && (cur_raw < cur_floor)) begin
			cur_fix = cur_floor;
		end else begin
			cur_fix = cur_raw;
		end
		if (volt_raw < `CHGSP_VOLT_MIN) begin
			volt_fix = `CHGSP_VOLT_MIN;
		end else if (volt_raw > `CHGSP_VOLT_MAX) begin
			volt_fix = `CHGSP_VOLT_MAX;
		end else begin
			volt_fix = volt_raw;
		end
	end

	assign clear_evt = battery_overcurrent_fault || !battery_present_input
		|| !adapter_valid_flag || wd_link.expire || safety_timer_event
		|| (charge_state_field == `CHGSP_STATE_DONE)
		|| (volt_commit && (volt_raw == 13'h0000));

	always_comb begin
		next_st = st;
		next_st.cur_buf = cur_asm;
		next_st.volt_buf = volt_asm;
		if (reg_wr_en) begin
			if (reg_addr == `CHGSP_ADDR_CUR_LO) next_st.cur_seen[0] = 1'b1;
			if (reg_addr == `CHGSP_ADDR_CUR_HI) next_st.cur_seen[1] = 1'b1;
			if (reg_addr == `CHGSP_ADDR_VOLT_LO) next_st.volt_seen[0] = 1'b1;
			if (reg_addr == `CHGSP_ADDR_VOLT_HI) next_st.volt_seen[1] = 1'b1;
		end
		if (cur_commit) begin
			next_st.cur = '0;
			next_st.cur[`CHGSP_CUR_MSB:`CHGSP_CUR_LSB] = cur_fix;
			next_st.cur_seen = 2'b00;
		end
		if (volt_commit) begin
			if (volt_raw != 13'h0000) begin
				next_st.volt = '0;
				next_st.volt[`CHGSP_VOLT_MSB:`CHGSP_VOLT_LSB] = volt_fix;
			end
			next_st.volt_seen = 2'b00;
		end
		if (clear_evt) begin
			next_st.cur = `CHGSP_CUR_RESET;
		end
		if (reg_reset_cmd || !st.init_done) begin
			next_st.cur = `CHGSP_CUR_RESET;
			next_st.volt = '0;
			next_st.volt[`CHGSP_VOLT_MSB:`CHGSP_VOLT_LSB] = volt_default;
			next_st.cur_seen = 2'b00;
			next_st.volt_seen = 2'b00;
			next_st.init_done = 1'b1;
		end
		next_st.chg_en = !charge_block_bit && (next_st.cur != 16'h0000)
			&& (next_st.volt[`CHGSP_VOLT_MSB:`CHGSP_VOLT_LSB] >= `CHGSP_VOLT_MIN)
			&& (next_st.volt[`CHGSP_VOLT_MSB:`CHGSP_VOLT_LSB] <= `CHGSP_VOLT_MAX);
		unique case (reg_rd_addr)
			`CHGSP_ADDR_CUR_LO: next_st.rdata = st.cur[7:0];
			`CHGSP_ADDR_CUR_HI: next_st.rdata = st.cur[15:8];
			`CHGSP_ADDR_VOLT_LO: next_st.rdata = st.volt[7:0];
			`CHGSP_ADDR_VOLT_HI: next_st.rdata = st.volt[15:8];
			default: next_st.rdata = 8'h00;
		endcase
	end

	// Strap is sampled after release, never inside the async reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{cur: `CHGSP_CUR_RESET, volt: `CHGSP_VOLT_RESET, cur_buf: 16'h0000,
				cur_seen: 2'b00, volt_buf: 16'h0000, volt_seen: 2'b00,
				init_done: 1'b0, chg_en: 1'b0, rdata: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign charge_current_limit = st.cur;
	assign charge_voltage_target = st.volt;
	assign charge_enable = st.chg_en;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence cur_over_pair_s;
		(reg_wr_en && reg_addr == `CHGSP_ADDR_CUR_LO && reg_wdata == 8'hF8
			&& st.cur_seen == 2'b00)
		##1 (reg_wr_en && reg_addr == `CHGSP_ADDR_CUR_HI && reg_wdata == 8'h3F
			&& !clear_evt && !reg_reset_cmd);
	endsequence

	rd_low_byte_a: assert property (reg_rd_addr == `CHGSP_ADDR_CUR_LO
		|=> reg_rdata == $past(st.cur[7:0]))
		else $error("current low byte read mismatch");
	cur_reserved_zero_a: assert property (st.cur[15:14] == 2'b00 && st.cur[2:0] == 3'h0)
		else $error("current reserved bits set");
	// Limit follows the sense option of the commit cycle
	cur_clamp_high_a: assert property (cur_over_pair_s |=> st.cur[13:3]
		== ($past(sense_resistor_select) ? 11'h5DC : 11'h7F8))
		else $error("current not clamped to maximum");
	// Floor is judged at commit; a later sense change does not rescale the stored code
	cur_floor_a: assert property (cur_commit && cur_raw != 11'h000 && !clear_evt
		&& !reg_reset_cmd && st.init_done |=> st.cur[13:3]
		>= ($past(sense_resistor_select) ? 11'h007 : 11'h010))
		else $error("current below 128mA floor");
	cur_max_2m_a: assert property (sense_resistor_select
		&& $stable(sense_resistor_select) && cur_commit |=> st.cur[13:3] <= 11'h5DC)
		else $error("current above 2 milliohm limit");
	cur_fault_clear_a: assert property ((battery_overcurrent_fault
		|| !adapter_valid_flag || !battery_present_input) |=> st.cur == 16'h0000)
		else $error("current not cleared on fault");
	cur_done_clear_a: assert property ((charge_state_field == 3'h7
		|| safety_timer_event || wd_link.expire) |=> st.cur == 16'h0000 && $stable(st.volt)
		|| $past(reg_reset_cmd))
		else $error("current not cleared on stop event");
	volt_zero_write_a: assert property (volt_commit && volt_raw == 13'h0000
		&& !reg_reset_cmd |=> $stable(st.volt) && st.cur == 16'h0000)
		else $error("zero voltage write misbehaved");
	volt_range_a: assert property (st.init_done |-> st.volt[14:2] >= 13'h04E2
		&& st.volt[14:2] <= 13'h1676 && st.volt[15] == 1'b0
		&& st.volt[1:0] == 2'b00)
		else $error("voltage outside range");
	volt_default_a: assert property (reg_reset_cmd
		&& cell_count == chgsp_pkg::CHGSP_CELLS_4
		|=> st.volt == 16'h41A0 && st.cur == 16'h0000)
		else $error("voltage default wrong after register reset");
	charge_gate_a: assert property (charge_block_bit |=> !charge_enable)
		else $error("charge enabled while inhibited");

endmodule : chgsp_top

// ===== verif/chgsp_host_model.sv
// Host side model: byte writes and reads on the setpoint register port.
// Assumes calls start on a falling clock edge; the bank samples on the rising edge.
`timescale 1ns/100ps
module chgsp_host_model (
	clk,
	reg_rdata,
	reg_wr_en,
	reg_addr,
	reg_wdata,
	reg_rd_addr
);
	input  wire logic       clk;
	input  wire logic [7:0] reg_rdata;
	output logic            reg_wr_en;
	output logic      [7:0] reg_addr;
	output logic      [7:0] reg_wdata;
	output logic      [7:0] reg_rd_addr;

	initial begin
		reg_wr_en   = 1'b0;
		reg_addr    = 8'hFF;
		reg_wdata   = 8'h00;
		reg_rd_addr = 8'hFF;
	end

	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		reg_wr_en = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge clk);
	endtask : write_byte

	// Inverted lines so a stale byte never looks valid
	task automatic release_bus();
		reg_wr_en = 1'b0;
		reg_addr  = ~reg_addr;
		reg_wdata = ~reg_wdata;
		@(negedge clk);
	endtask : release_bus

	task automatic write_word(input logic [7:0] a, input logic [15:0] v);
		write_byte(a, v[7:0]);
		write_byte(a + 8'h01, v[15:8]);
		release_bus();
	endtask : write_word

	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		reg_rd_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : read_byte
endmodule : chgsp_host_model

// ===== verif/charge_setpoint_registers_bench.sv
// Self-checking bench of the charge setpoint bank, driven through the host model.
// Assumes a shortened watchdog second of 10 clocks.
`timescale 1ns/100ps
module charge_setpoint_registers_bench;
	localparam int unsigned TPS = 10;
	logic                     clk = 1'b0;
	logic                     rst;
	logic                     reg_wr_en;
	logic [7:0]               reg_addr;
	logic [7:0]               reg_wdata;
	logic [7:0]               reg_rd_addr;
	logic [7:0]               reg_rdata;
	logic                     reg_reset_cmd;
	chgsp_pkg::chgsp_cells_t  cell_count;
	logic                     sense_resistor_select;
	chgsp_pkg::chgsp_wd_sel_t watchdog_period_select;
	logic                     charge_block_bit;
	logic                     battery_overcurrent_fault;
	logic                     battery_present_input;
	logic                     adapter_valid_flag;
	logic [2:0]               charge_state_field;
	logic                     safety_timer_event;
	logic [15:0]              cur;
	logic [15:0]              volt;
	logic                     en;
	logic [7:0]               rd;
	logic [15:0]              vdef [4];
	int                       fail_count;
	int                       check_count;

	chgsp_top #(.WD_TICKS_PER_SEC(TPS)) i_dut (
		.clk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rd_addr, .reg_rdata,
		.reg_reset_cmd, .cell_count, .sense_resistor_select, .watchdog_period_select,
		.charge_block_bit, .battery_overcurrent_fault, .battery_present_input,
		.adapter_valid_flag, .charge_state_field, .safety_timer_event,
		.charge_current_limit(cur), .charge_voltage_target(volt), .charge_enable(en)
	);

	chgsp_host_model i_host (
		.clk, .reg_rdata, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rd_addr
	);

	always #2 clk = ~clk;

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		i_host.write_word(a, v);
	endtask : wr

	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// Run takes about 2800 cycles; the limit leaves wide margin
	initial begin
		#40000;
		fail_count++;
		$display("FAIL run time expected done seen timeout");
		print_verdict();
	end

	initial begin
		vdef = '{16'h20D0, 16'h3138, 16'h41A0, 16'h5208};
		rst = 1'b1;
		reg_reset_cmd = 1'b0;
		cell_count = chgsp_pkg::CHGSP_CELLS_4;
		sense_resistor_select = 1'b0;
		watchdog_period_select = chgsp_pkg::CHGSP_WD_OFF;
		charge_block_bit = 1'b0;
		battery_overcurrent_fault = 1'b0;
		battery_present_input = 1'b1;
		adapter_valid_flag = 1'b1;
		charge_state_field = 3'h0;
		safety_timer_event = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk("cur reset", cur, 16'h0000);
		chk("volt default", volt, 16'h41A0);
		i_host.read_byte(8'h05, rd);
		chk("volt hi byte", {8'h00, rd}, 16'h0041);
		wr(8'h02, 16'hFFFF);
		chk("cur clamp", cur, 16'h3FC0);
		chk("enable", {15'h0000, en}, 16'h0001);
		i_host.read_byte(8'h02, rd);
		chk("cur lo byte", {8'h00, rd}, 16'h00C0);
		i_host.read_byte(8'h06, rd);
		chk("unmapped", {8'h00, rd}, 16'h0000);
		wr(8'h02, 16'h0008);
		chk("cur floor", cur, 16'h0080);
		wr(8'h02, 16'h0000);
		chk("cur zero", cur, 16'h0000);
		chk("enable off", {15'h0000, en}, 16'h0000);
		i_host.write_byte(8'h02, 8'h40);
		i_host.release_bus();
		chk("lone byte", cur, 16'h0000);
		i_host.write_byte(8'h03, 8'h01);
		i_host.release_bus();
		chk("pair done", cur, 16'h0140);
		charge_block_bit = 1'b1;
		@(negedge clk);
		chk("inhibit", {15'h0000, en}, 16'h0000);
		charge_block_bit = 1'b0;
		sense_resistor_select = 1'b1;
		wr(8'h02, 16'h3FF8);
		chk("cur clamp 2m", cur, 16'h2EE0);
		wr(8'h02, 16'h0008);
		chk("cur floor 2m", cur, 16'h0038);
		sense_resistor_select = 1'b0;
		for (int k = 0; k < 5; k++) begin
			wr(8'h02, 16'h0400);
			case (k)
				0: battery_overcurrent_fault = 1'b1;
				1: battery_present_input = 1'b0;
				2: adapter_valid_flag = 1'b0;
				3: charge_state_field = 3'h7;
				default: safety_timer_event = 1'b1;
			endcase
			@(negedge clk);
			battery_overcurrent_fault = 1'b0;
			battery_present_input = 1'b1;
			adapter_valid_flag = 1'b1;
			charge_state_field = 3'h0;
			safety_timer_event = 1'b0;
			chk("cur cleared", cur, 16'h0000);
		end
		wr(8'h02, 16'h0400);
		wr(8'h04, 16'h0000);
		chk("volt kept", volt, 16'h41A0);
		chk("cur stopped", cur, 16'h0000);
		wr(8'h04, 16'h0004);
		chk("volt low clamp", volt, 16'h1388);
		wr(8'h04, 16'hFFFF);
		chk("volt high clamp", volt, 16'h59D8);
		wr(8'h04, 16'h2002);
		chk("volt field", volt, 16'h2000);
		i_host.write_byte(8'h05, 8'h30);
		i_host.write_byte(8'h04, 8'h00);
		i_host.release_bus();
		chk("high byte first", volt, 16'h3000);
		wr(8'h02, 16'h0400);
		for (int c = 0; c < 4; c++) begin
			cell_count = chgsp_pkg::chgsp_cells_t'(c[1:0]);
			reg_reset_cmd = 1'b1;
			@(negedge clk);
			reg_reset_cmd = 1'b0;
			chk("cell default", volt, vdef[c]);
			chk("cur reg reset", cur, 16'h0000);
		end
		watchdog_period_select = chgsp_pkg::CHGSP_WD_P1;
		wr(8'h02, 16'h0400);
		repeat (40) @(negedge clk);
		chk("wd before", cur, 16'h0400);
		repeat (20) @(negedge clk);
		chk("wd expired", cur, 16'h0000);
		chk("wd keeps volt", volt, 16'h5208);
		wr(8'h02, 16'h0400);
		chk("wd resumed", cur, 16'h0400);
		for (int p = 2; p < 4; p++) begin
			watchdog_period_select = chgsp_pkg::chgsp_wd_sel_t'(p[1:0]);
			wr(8'h02, 16'h0400);
			repeat ((p == 2) ? 870 : 1740) @(negedge clk);
			chk("wd long before", cur, 16'h0400);
			repeat (20) @(negedge clk);
			chk("wd long expired", cur, 16'h0000);
		end
		print_verdict();
	end
endmodule : charge_setpoint_registers_bench
